// *** frs_core_model.sv ***
// Core-side bus master model that drives the sequencer registers.
// Assumes one AHB-Lite slave whose hreadyout is fed back as hready.
`timescale 1ns/1ps
module frs_core_model (
  input  wire logic        hclk,
  input  wire logic        hready,
  input  wire logic [31:0] hrdata,
  input  wire logic        core_stall,
  output logic             hsel,
  output logic [31:0]      haddr,
  output logic [1:0]       htrans,
  output logic             hwrite,
  output logic [2:0]       hsize,
  output logic [31:0]      hwdata
);
  initial begin
    hsel   = 1'b1;
    haddr  = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize  = 3'h2;
    hwdata = 32'h0;
  end

  // Entered just after a rising edge, so back-to-back transfers need no gap.
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] r);
    haddr  <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    r = hrdata;
  endtask

  task automatic start_op(input logic [31:0] ctrl, input logic keys);
    logic [31:0] r;
    // Mode bits set before the start.
    // Key pair on consecutive writes.
    // Without keys only the start write goes out, so earlier key writes stay in force.
    if (keys) begin
      xfer(1'b1, frs_pkg::CTRL_ADDR, ctrl, r);
      xfer(1'b1, frs_pkg::KEY_ADDR, {24'h0, frs_pkg::KEY_FIRST}, r);
      xfer(1'b1, frs_pkg::KEY_ADDR, {24'h0, frs_pkg::KEY_SECOND}, r);
    end
    xfer(1'b1, frs_pkg::CTRL_ADDR, ctrl | 32'h8000, r);
    repeat (2) @(posedge hclk);
    while (core_stall === 1'b1) @(posedge hclk);
  endtask
endmodule

// *** frs_pkg.sv ***
// Package for the flash row program and erase sequencer.
// Assumes a 32-bit AHB-Lite register bus and a 125 MHz system clock.
package frs_pkg;
  // Register byte addresses.
  localparam logic [7:0] CTRL_ADDR   = 8'h00;
  localparam logic [7:0] KEY_ADDR    = 8'h04;
  localparam logic [7:0] PAGE_ADDR   = 8'h08;
  localparam logic [7:0] OFFS_ADDR   = 8'h0c;
  localparam logic [7:0] BUFI_ADDR   = 8'h10;
  localparam logic [7:0] BUFD_ADDR   = 8'h14;
  localparam logic [7:0] STAT_ADDR   = 8'h18;
  localparam logic [7:0] MASK_ADDR   = 8'h1c;
  localparam logic [7:0] FLASH_ADDR  = 8'h20;
  // Control register fields.
  localparam int START_BIT = 15;
  localparam int ENABLE_BIT = 14;
  localparam int ERASE_BIT = 6;
  localparam int OP_HI = 3;
  localparam int OP_LO = 0;
  localparam logic [3:0] OP_ERASE   = 4'h2;
  localparam logic [3:0] OP_PROGRAM = 4'h1;
  // Unlock key values and field width.
  localparam logic [7:0] KEY_FIRST  = 8'h55;
  localparam logic [7:0] KEY_SECOND = 8'haa;
  localparam int KEY_W = 8;
  // Geometry.
  localparam int ROW_WORDS   = 64;
  localparam int PAGE_ROWS   = 8;
  localparam int PAGE_WORDS  = 512;
  localparam int WORD_W      = 24;
  localparam int IDX_W       = 6;
  localparam int ADDR_W      = 16;
  // Cycle times.
  localparam int CLK_MHZ     = 125;
  localparam int PROG_TIME_US  = 20;
  localparam int ERASE_TIME_US = 20;
  localparam int PROG_CYC  = PROG_TIME_US * CLK_MHZ;
  localparam int ERASE_CYC = ERASE_TIME_US * CLK_MHZ;
  localparam int CNT_W = 16;
  // Status bits.
  localparam int ST_DONE = 0;
  localparam int ST_REFUSED = 1;
  localparam int ST_W = 2;
  typedef enum logic [1:0] {FRS_IDLE, FRS_RUN} frs_state_e;
endpackage

// *** frs_sequencer.sv ***
// Flash row program and page erase sequencer with an AHB-Lite register slave.
// Assumes one AHB-Lite master, single word transfers, and a flash port that accepts
// one word write per cycle while the sequencer runs.
// What this block does
// [R1] Reads of the unlock key register return zero in bits 15 to 8.
// [R2] The key bits 7 to 0 are write only and never read back a stored value.
// [R3] Programming writes one row, erase clears the whole eight-row page holding the row.
// [R4] An erase page is 512 instruction words over eight rows.
// [R5] Operation code 0010 in control bits 3 to 0 selects a page erase.
// [R6] An erase needs the erase bit 6 and the enable bit 14 set before starting.
// [R7] Software loads the page start into the table page pointer and offset before an erase.
// [R8] Writing 0x55 then 0xAA to the key register unlocks before the start bit is set.
// [R9] Setting start bit 15 launches the cycle and the block clears it at the end.
// [R10] The core is held stalled for the whole cycle and released when it ends.
// [R11] Operation code 0001 with erase clear and enable set selects row programming.
// [R12] The 64-word row buffer is filled before a row program starts.
// [R13] Software repeats buffer load and row program, stepping the offset, for a page.
// [R14] No erase or program runs unless the unlock sequence came first.
// [R15] Software waits out the full cycle time before assuming completion.
// [R16] Software should issue two no-operations right after setting the start bit.
// [R17] The unlock arms only on consecutive key writes and any other write or a launch disarms it.
`timescale 1ns/1ps
module frs_sequencer (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic [31:0]      hrdata,
  output logic             hreadyout,
  output logic             hresp,
  output logic             core_stall,
  output logic             flash_we,
  output logic [15:0]      flash_addr,
  output logic [23:0]      flash_wdata,
  output logic             flash_erase,
  output logic             irq
);
  // Address phase capture.
  logic        ap_wr_q;
  logic        ap_rd_q;
  logic [7:0]  ap_addr_q;
  logic        take;

  // Registers.
  logic [15:0] ctrl_q;
  logic [15:0] page_q;
  logic [15:0] offs_q;
  logic [5:0]  bidx_q;
  logic [1:0]  stat_q;
  logic [1:0]  mask_q;
  logic [23:0] row_buf [0:63];
  frs_pkg::frs_state_e st_q;

  // Row walk state.
  logic [5:0]  widx_q;
  logic        wwalk_q;
  logic [23:0] fdata_q;
  logic [15:0] faddr_q;
  logic        fwe_q;
  logic        ferase_q;

  // Decode wires.
  logic wr_ctrl;
  logic wr_key;
  logic wr_page;
  logic wr_offs;
  logic wr_bidx;
  logic wr_bdat;
  logic wr_stat;
  logic wr_mask;
  logic wr_other;
  logic unlocked;
  logic start_req;
  logic op_erase;
  logic op_prog;
  logic launch;
  logic refuse;
  logic t_busy;
  logic t_done;
  logic [15:0] t_count;
  logic [31:0] rd_mux;
  logic [15:0] page_base;
  logic [15:0] row_base;

  assign take = hsel && hready && htrans[1];
  assign wr_ctrl = ap_wr_q && (ap_addr_q == frs_pkg::CTRL_ADDR);
  assign wr_key  = ap_wr_q && (ap_addr_q == frs_pkg::KEY_ADDR);
  assign wr_page = ap_wr_q && (ap_addr_q == frs_pkg::PAGE_ADDR);
  assign wr_offs = ap_wr_q && (ap_addr_q == frs_pkg::OFFS_ADDR);
  assign wr_bidx = ap_wr_q && (ap_addr_q == frs_pkg::BUFI_ADDR);
  assign wr_bdat = ap_wr_q && (ap_addr_q == frs_pkg::BUFD_ADDR);
  assign wr_stat = ap_wr_q && (ap_addr_q == frs_pkg::STAT_ADDR);
  assign wr_mask = ap_wr_q && (ap_addr_q == frs_pkg::MASK_ADDR);
  assign wr_other = ap_wr_q && !wr_key;

  // [R5] erase operation code
  // [R6] erase and enable bits
  assign op_erase = (hwdata[frs_pkg::OP_HI:frs_pkg::OP_LO] == frs_pkg::OP_ERASE)
                    && hwdata[frs_pkg::ERASE_BIT] && hwdata[frs_pkg::ENABLE_BIT];
  // [R11] program operation code
  assign op_prog  = (hwdata[frs_pkg::OP_HI:frs_pkg::OP_LO] == frs_pkg::OP_PROGRAM)
                    && !hwdata[frs_pkg::ERASE_BIT] && hwdata[frs_pkg::ENABLE_BIT];
  assign start_req = wr_ctrl && hwdata[frs_pkg::START_BIT] && (st_q == frs_pkg::FRS_IDLE);
  // [R14] launch only when unlocked
  assign launch = start_req && unlocked && (op_erase || op_prog);
  assign refuse = start_req && !launch;
  assign t_count = op_erase ? 16'(frs_pkg::ERASE_CYC) : 16'(frs_pkg::PROG_CYC);

  // [R3] page base clears the row bits
  // [R4] 512 words per page
  assign page_base = offs_q & ~16'(frs_pkg::PAGE_WORDS - 1);
  assign row_base  = offs_q & ~16'(frs_pkg::ROW_WORDS - 1);

  // [R1] upper key bits read zero
  // [R2] key never read back
  assign rd_mux = (ap_addr_q == frs_pkg::CTRL_ADDR) ? {16'h0000, ctrl_q} :
                  (ap_addr_q == frs_pkg::KEY_ADDR)  ? 32'h00000000 :
                  (ap_addr_q == frs_pkg::PAGE_ADDR) ? {16'h0000, page_q} :
                  (ap_addr_q == frs_pkg::OFFS_ADDR) ? {16'h0000, offs_q} :
                  (ap_addr_q == frs_pkg::BUFI_ADDR) ? {26'h0000000, bidx_q} :
                  (ap_addr_q == frs_pkg::STAT_ADDR) ? {30'h00000000, stat_q} :
                  (ap_addr_q == frs_pkg::MASK_ADDR) ? {30'h00000000, mask_q} :
                  32'h00000000;

  // [R10] core stalled while busy
  assign core_stall = (st_q == frs_pkg::FRS_RUN);
  // A read's data phase takes one wait cycle so hrdata is registered from the settled
  // registers, which also lets a read see a write that ended just before it.
  assign hreadyout = !ap_rd_q;
  assign hresp = 1'b0;
  assign irq = |(stat_q & mask_q);
  assign flash_we = fwe_q;
  assign flash_addr = faddr_q;
  assign flash_wdata = fdata_q;
  assign flash_erase = ferase_q;

  frs_unlock u_unlock (
    .hclk     (hclk),
    .hresetn  (hresetn),
    .key_we   (wr_key),
    .other_we (wr_other),
    .key_data (hwdata[frs_pkg::KEY_W-1:0]),
    .launch   (launch),
    .unlocked (unlocked)
  );

  frs_timer u_timer (
    .hclk    (hclk),
    .hresetn (hresetn),
    .load    (launch),
    .count   (t_count),
    .busy    (t_busy),
    .done    (t_done)
  );

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ap_wr_q   <= 1'b0;
      ap_rd_q   <= 1'b0;
      ap_addr_q <= 8'h00;
      hrdata    <= 32'h00000000;
    end else begin
      ap_wr_q   <= take && hwrite;
      ap_rd_q   <= take && !hwrite;
      ap_addr_q <= haddr[7:0];
      hrdata    <= (take && !hwrite) ? 32'h00000000 : hrdata;
      if (ap_rd_q) begin
        hrdata <= rd_mux;
      end
    end
  end

  // [R9] start launches and self clears
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_q <= 16'h0000;
      st_q   <= frs_pkg::FRS_IDLE;
    end else begin
      if (st_q == frs_pkg::FRS_RUN && t_done) begin
        st_q <= frs_pkg::FRS_IDLE;
        ctrl_q[frs_pkg::START_BIT] <= 1'b0;
      end else if (launch) begin
        st_q   <= frs_pkg::FRS_RUN;
        ctrl_q <= hwdata[15:0];
      end else if (wr_ctrl && st_q == frs_pkg::FRS_IDLE) begin
        ctrl_q <= {1'b0, hwdata[14:0]};
      end
    end
  end

  // [R7] page pointer and offset
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      page_q <= 16'h0000;
      offs_q <= 16'h0000;
      mask_q <= 2'h0;
    end else begin
      if (wr_page) begin
        page_q <= hwdata[15:0];
      end
      if (wr_offs) begin
        offs_q <= hwdata[15:0];
      end
      if (wr_mask) begin
        mask_q <= hwdata[frs_pkg::ST_W-1:0];
      end
    end
  end

  // [R12] row buffer fill
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bidx_q <= 6'h00;
    end else if (wr_bidx) begin
      bidx_q <= hwdata[frs_pkg::IDX_W-1:0];
    end else if (wr_bdat) begin
      bidx_q <= bidx_q + 6'h01;
    end
  end

  always_ff @(posedge hclk) begin
    if (wr_bdat) begin
      row_buf[bidx_q] <= hwdata[frs_pkg::WORD_W-1:0];
    end
  end

  // Set wins over a write-one clear so an event is never lost.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      stat_q <= 2'h0;
    end else begin
      stat_q <= (stat_q & ~(wr_stat ? hwdata[frs_pkg::ST_W-1:0] : 2'h0))
                | {refuse, (st_q == frs_pkg::FRS_RUN) && t_done};
    end
  end

  // [R3] one row per program
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      widx_q   <= 6'h00;
      wwalk_q  <= 1'b0;
      fwe_q    <= 1'b0;
      ferase_q <= 1'b0;
      faddr_q  <= 16'h0000;
      fdata_q  <= 24'h000000;
    end else begin
      fwe_q    <= 1'b0;
      ferase_q <= 1'b0;
      if (launch && op_erase) begin
        ferase_q <= 1'b1;
        faddr_q  <= page_base;
      end else if (launch && op_prog) begin
        wwalk_q <= 1'b1;
        widx_q  <= 6'h00;
      end else if (wwalk_q) begin
        fwe_q   <= 1'b1;
        faddr_q <= row_base | {10'h000, widx_q};
        fdata_q <= row_buf[widx_q];
        widx_q  <= widx_q + 6'h01;
        if (widx_q == 6'(frs_pkg::ROW_WORDS - 1)) begin
          wwalk_q <= 1'b0;
        end
      end
    end
  end

  a_key_reads_zero: assert property (@(posedge hclk) disable iff (!hresetn) // [R1]
    ap_rd_q && ap_addr_q == frs_pkg::KEY_ADDR |=> hrdata == 32'h00000000)
    else $error("Key register read returned data.");

  a_stall_on_launch: assert property (@(posedge hclk) disable iff (!hresetn) // [R10]
    launch |=> core_stall [*8])
    else $error("Core not stalled after launch.");

  a_locked_no_run: assert property (@(posedge hclk) disable iff (!hresetn) // [R14]
    start_req && !unlocked |=> !core_stall)
    else $error("Cycle started without unlock.");

  a_start_self_clr: assert property (@(posedge hclk) disable iff (!hresetn) // [R9]
    core_stall && t_done |=> !ctrl_q[frs_pkg::START_BIT] && !core_stall)
    else $error("Start bit not cleared at cycle end.");

  // A single-transfer master leaves one address cycle between two write data phases.
  sequence s_key_pair;
    wr_key && hwdata[7:0] == frs_pkg::KEY_FIRST ##1 !ap_wr_q ##1
      wr_key && hwdata[7:0] == frs_pkg::KEY_SECOND;
  endsequence
  a_unlock_arms: assert property (@(posedge hclk) disable iff (!hresetn) // [R8]
    s_key_pair |=> unlocked)
    else $error("Key pair did not unlock.");

  a_other_disarms: assert property (@(posedge hclk) disable iff (!hresetn) // [R17]
    wr_other || launch |=> !unlocked)
    else $error("Unlock survived another write.");

  a_erase_pulse: assert property (@(posedge hclk) disable iff (!hresetn) // [R5]
    launch && op_erase |=> flash_erase && flash_addr == page_base)
    else $error("Erase not issued at page base.");

  a_row_walk: assert property (@(posedge hclk) disable iff (!hresetn) // [R12]
    launch && op_prog |=> ##1 flash_we [*8])
    else $error("Row program did not write buffer words.");
endmodule

// *** frs_timer.sv ***
// Down counter that times one erase or program cycle.
// Assumes load is a one-cycle pulse while the counter is idle.
`timescale 1ns/1ps
module frs_timer (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        load,
  input  wire logic [15:0] count,
  output logic             busy,
  output logic             done
);
  logic [15:0] cnt_q;
  logic [15:0] cnt_d;

  assign cnt_d = load ? count : ((cnt_q != 16'h0000) ? cnt_q - 16'h0001 : cnt_q);
  assign busy  = (cnt_q != 16'h0000);
  assign done  = (cnt_q == 16'h0001);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_q <= 16'h0000;
    end else begin
      cnt_q <= cnt_d;
    end
  end
endmodule

// *** frs_unlock.sv ***
// Unlock key tracker for the sequencer.
// Assumes key writes and other register writes arrive as one-cycle strobes.
`timescale 1ns/1ps
module frs_unlock (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        key_we,
  input  wire logic        other_we,
  input  wire logic [7:0]  key_data,
  input  wire logic        launch,
  output logic             unlocked
);
  logic half_q;
  logic half_d;
  logic unl_q;
  logic unl_d;

  // [R17] consecutive key writes
  assign half_d = key_we ? (key_data == frs_pkg::KEY_FIRST) : (other_we ? 1'b0 : half_q);
  // [R8] second key arms
  assign unl_d = launch ? 1'b0 :
                 key_we ? (half_q && key_data == frs_pkg::KEY_SECOND) :
                 (other_we ? 1'b0 : unl_q);
  assign unlocked = unl_q;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      half_q <= 1'b0;
      unl_q  <= 1'b0;
    end else begin
      half_q <= half_d;
      unl_q  <= unl_d;
    end
  end
endmodule

// *** tb_top.sv ***
// Self-checking bench for the flash sequencer, with a queue-based reference.
// Assumes the core model above and the cycle times in the package.
`timescale 1ns/1ps
module tb_top;
  logic        hclk;
  logic        hresetn;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic        core_stall;
  logic        flash_we;
  logic [15:0] flash_addr;
  logic [23:0] flash_wdata;
  logic        flash_erase;
  logic        irq;
  int          fails;
  int          cmp_count;
  int          cyc;
  int          stall_n;
  int          erase_n;
  int          n;
  int          e;
  logic [31:0] seed;
  logic [31:0] r;
  logic [31:0] d;
  logic [15:0] offs;
  logic [15:0] erase_a;
  logic [15:0] wa_q[$];
  logic [23:0] wd_q[$];
  logic [23:0] exp_q[$];

  frs_sequencer DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .core_stall(core_stall),
    .flash_we(flash_we), .flash_addr(flash_addr), .flash_wdata(flash_wdata),
    .flash_erase(flash_erase), .irq(irq));

  frs_core_model core (.hclk(hclk), .hready(hreadyout), .hrdata(hrdata),
    .core_stall(core_stall), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));

  initial hclk = 1'b0;
  always #4 hclk = ~hclk;

  task automatic tally_and_finish();
    if (fails == 0 && cmp_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    logic [31:0] x;
    core.xfer(1'b1, a, v, x);
  endtask

  task automatic rd(input logic [7:0] a);
    core.xfer(1'b0, a, 32'h0, r);
  endtask

  // Stall length must cover the whole cycle time with a small margin.
  task automatic win(input int v, input int lo, input string m);
    chk((v >= lo && v <= lo + 70) ? 32'h1 : 32'h0, 32'h1, m);
  endtask

  always @(posedge hclk) begin
    cyc++;
    if (core_stall === 1'b1) stall_n++;
    if (flash_erase === 1'b1) begin
      erase_n++;
      erase_a = flash_addr;
    end
    if (flash_we === 1'b1) begin
      wa_q.push_back(flash_addr);
      wd_q.push_back(flash_wdata);
    end
    if (cyc == 20000) begin
      fails++;
      tally_and_finish();
    end
  end

  initial begin
    seed = 32'h3563;
    hresetn = 1'b0;
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    chk({26'h0, irq, core_stall, flash_we, flash_erase, hresp, hreadyout}, 32'h1, "reset state");
    wr(frs_pkg::KEY_ADDR, $random(seed));
    rd(frs_pkg::KEY_ADDR);
    chk(r, 32'h0, "key read"); // Key reads as zero.
    rd(8'h40);
    chk(r, 32'h0, "unmapped");
    wr(frs_pkg::MASK_ADDR, 32'h3);
    offs = 16'($random(seed)) & 16'hffc0;
    wr(frs_pkg::PAGE_ADDR, 32'h0); // Page pointer set.
    wr(frs_pkg::OFFS_ADDR, {16'h0, offs}); // Offset set.
    e = erase_n;
    n = stall_n;
    core.start_op(32'h4042, 1'b1); // Erase launch.
    chk(erase_n - e, 1, "erase count"); // Single page erase.
    chk(erase_a, offs & 16'hfe00, "erase base"); // Page of 512 words.
    win(stall_n - n, frs_pkg::ERASE_CYC, "erase stall"); // Core held.
    rd(frs_pkg::CTRL_ADDR);
    chk(r & 32'h800f, 32'h2, "ctrl after"); // Start bit cleared.
    rd(frs_pkg::STAT_ADDR);
    chk(r, 32'h1, "done"); // Completion flagged.
    chk(irq, 1'b1, "irq on");
    wr(frs_pkg::STAT_ADDR, 32'h1);
    // The write lands on the edge that ends the transfer, so irq is looked at one edge later.
    @(posedge hclk);
    chk(irq, 1'b0, "irq clr");
    for (int w = 0; w < 2; w++) begin
      wr(frs_pkg::OFFS_ADDR, {16'h0, offs + 16'(w * 64)}); // Next row.
      wr(frs_pkg::BUFI_ADDR, 32'h0);
      for (int i = 0; i < 64; i++) begin
        d = $random(seed) & 32'hffffff;
        exp_q.push_back(d[23:0]);
        wr(frs_pkg::BUFD_ADDR, d); // Row buffer load.
      end
      wa_q.delete();
      wd_q.delete();
      n = stall_n;
      core.start_op(32'h4001, 1'b1); // Row program.
      chk(wa_q.size(), 64, "row words"); // One row only.
      for (int i = 0; i < 64 && i < wa_q.size(); i++) begin
        chk(wd_q[i], exp_q.pop_front(), "wdata"); // Buffer contents.
        chk(wa_q[i], 16'(offs + w * 64 + i), "waddr"); // Row addresses.
      end
      exp_q.delete();
      win(stall_n - n, frs_pkg::PROG_CYC, "prog stall"); // Core held.
      rd(frs_pkg::STAT_ADDR);
      chk(r, 32'h1, "prog done"); // Completion flagged.
      wr(frs_pkg::STAT_ADDR, 32'h1);
    end
    // Locked starts: no key, keys in the wrong order, and a pair split by another write.
    for (int k = 0; k < 3; k++) begin
      if (k == 1) begin
        wr(frs_pkg::KEY_ADDR, 32'haa);
        wr(frs_pkg::KEY_ADDR, 32'h55);
      end
      if (k == 2) begin
        wr(frs_pkg::KEY_ADDR, 32'h55);
        wr(frs_pkg::MASK_ADDR, 32'h3);
        wr(frs_pkg::KEY_ADDR, 32'haa);
      end
      n = stall_n;
      core.start_op(32'h4001, 1'b0);
      chk(stall_n - n, 0, "no stall"); // Locked start refused.
      rd(frs_pkg::STAT_ADDR);
      chk(r, 32'h2, "refused"); // Refusal flagged.
      chk(irq, 1'b1, "irq ref");
      wr(frs_pkg::MASK_ADDR, 32'h1);
      @(posedge hclk);
      chk(irq, 1'b0, "irq masked");
      wr(frs_pkg::STAT_ADDR, 32'h2);
      wr(frs_pkg::MASK_ADDR, 32'h3);
      @(posedge hclk);
      chk(irq, 1'b0, "irq w1c");
    end
    tally_and_finish();
  end
endmodule
